// File: rtl/lbca_defines.vh
// Constants of the local bus controller and arbiter, with its contract.
// Contract
// - No memory/IO pin; top status line low means I/O, high memory.
// - Transceiver enable is low during memory, I/O and interrupt acknowledge cycles.
// - Transceiver direction high on writes, low on reads.
// - On grant, float strobes, status, lock, address/data, upper address, byte-high.
// - External request ranks below refresh, above all other internal requests.
// - Finish any bus cycle in progress before granting the bus.
// - Grant latency may reach four bus cycles, sixteen clocks or more.
// - Grant waits for any locked transfer sequence to complete.
// - While granted, a pending refresh drops grant low to reclaim bus.
// - Bus retaken for refresh only after the master drops its request.
// - In reset, drive enable and strobes high one clock, then float.
// - In reset, status high then float; float data; latch strobe, grant low.
// - Strap pullups during reset; read strap low selects queue status mode.
// - Both memory selects low at reset selects pin-float emulation mode.
// - Test pin low in reset, high afterwards, selects enhanced mode.
// - Peripheral control sits in 16-bit registers of a 256-byte block.
// - Block accesses run a visible cycle but ignore data and readies.
// - Block base on 256-byte boundary; relocation register at 0xfe gives 12 bits.
// - Bit 12 selects memory space when set; I/O needs top bits zero.
// - Bit 14 sets interrupt controller slave mode, clear for master.
// - Relocation register resets to 0x20ff, block at 0xff00 in I/O.
// - Reset output held at least five clocks for six-clock input.
`ifndef LBCA_DEFINES_VH
`define LBCA_DEFINES_VH
`define LBCA_RELOC_OFFSET 8'hfe
`define LBCA_RELOC_RESET 16'h20ff
`define LBCA_RELOC_MEM_BIT 12
`define LBCA_RELOC_SLAVE_BIT 14
`define LBCA_RESET_HOLD 3'h5
`define LBCA_STAT_IDLE 3'h7
`define LBCA_STAT_IRQ_ACK_CYCLE 3'h0
`define LBCA_STAT_IORD 3'h1
`define LBCA_STAT_IOWR 3'h2
`define LBCA_STAT_MEMRD 3'h5
`define LBCA_STAT_MEMWR 3'h6
`endif

// File: rtl/lbca_local_bus_ctrl.v
// Local bus control, hold arbitration, strap capture and control block decode.
`timescale 1ns/1ps
`default_nettype none
`include "lbca_defines.vh"
module lbca_local_bus_ctrl (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire reset_in_n_i,
  input wire cyc_req_i,
  input wire [2:0] cyc_status_i,
  input wire cyc_lock_i,
  input wire cyc_done_i,
  input wire [19:0] cyc_addr_i,
  input wire [15:0] cyc_wdata_i,
  input wire refresh_req_i,
  input wire hold_req_i,
  input wire read_or_queue_strap_i,
  input wire upper_mem_select_i,
  input wire lower_mem_select_i,
  input wire test_pin_i,
  output reg cyc_ack_o,
  output reg refresh_ack_o,
  output reg transceiver_enable_o,
  output reg transceiver_enable_oe_o,
  output reg transceiver_direction_o,
  output reg transceiver_direction_oe_o,
  output reg rd_n_o,
  output reg wr_n_o,
  output reg strobe_oe_o,
  output reg [2:0] bus_status_lines_o,
  output reg bus_status_oe_o,
  output reg addr_latch_o,
  output reg bus_oe_o,
  output reg bus_grant_out_o,
  output reg strap_pullup_en_o,
  output reg queue_status_mode_o,
  output reg pin_float_emulation_mode_o,
  output reg enhanced_mode_o,
  output reg reset_out_o,
  output reg cb_select_o,
  output reg cb_ignore_ready_o,
  output reg [15:0] control_block_relocation_o,
  output reg irq_slave_mode_o
);
  // ****************************************************************
  // Synchronisers and reset
  // ****************************************************************
  reg [1:0] res_s_r;
  reg [1:0] hold_s_r;
  reg [1:0] refresh_indicator_s_r;
  reg [3:0] strap_m_r;
  reg [3:0] strap_s_r;
  reg [2:0] rst_cnt_r;
  reg rst_first_r;
  wire in_reset;
  wire hold_s;
  always @(posedge sys_clk_i) begin
    res_s_r <= {res_s_r[0], reset_in_n_i};
    hold_s_r <= {hold_s_r[0], hold_req_i};
    refresh_indicator_s_r <= {refresh_indicator_s_r[0], refresh_req_i};
    strap_m_r <= {read_or_queue_strap_i, upper_mem_select_i,
                  lower_mem_select_i, test_pin_i};
    strap_s_r <= strap_m_r;
  end
  assign in_reset = ~nrst_i | ~res_s_r[1];
  assign hold_s = hold_s_r[1];
  // Stretch so a six-clock input yields at least five clocks out.
  always @(posedge sys_clk_i) begin
    if (in_reset) begin
      rst_cnt_r <= `LBCA_RESET_HOLD;
      reset_out_o <= 1'b1;
    end else if (rst_cnt_r != 3'h0) begin
      rst_cnt_r <= rst_cnt_r - 3'h1;
      reset_out_o <= 1'b1;
    end else begin
      reset_out_o <= 1'b0;
    end
  end
  // ****************************************************************
  // Strap capture
  // ****************************************************************
  reg test_low_seen_r;
  always @(posedge sys_clk_i) begin
    if (in_reset) begin
      strap_pullup_en_o <= 1'b1;
      queue_status_mode_o <= ~strap_s_r[3];
      pin_float_emulation_mode_o <= ~strap_s_r[2] & ~strap_s_r[1];
      test_low_seen_r <= ~strap_s_r[0];
      enhanced_mode_o <= 1'b0;
    end else begin
      strap_pullup_en_o <= 1'b0;
      if (test_low_seen_r && strap_s_r[0])
        enhanced_mode_o <= 1'b1;
    end
  end
  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  localparam ST_RST1 = 6'h01;
  localparam ST_IDLE = 6'h02;
  localparam ST_ADDR = 6'h04;
  localparam ST_DATA = 6'h08;
  localparam ST_HOLD = 6'h10;
  localparam ST_RECL = 6'h20;
  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg locked_r;
  reg is_write_r;
  reg is_refresh_indicator_r;
  reg [2:0] stat_r;
  wire refresh_indicator = refresh_indicator_s_r[1];
  function is_wr;
    input [2:0] s;
    begin
      is_wr = (s == `LBCA_STAT_IOWR) | (s == `LBCA_STAT_MEMWR);
    end
  endfunction
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RST1: state_nxt = ST_IDLE;
      ST_IDLE: begin
        // Refresh first, then hold, then internal requests.
        if (refresh_indicator) state_nxt = ST_ADDR;
        else if (hold_s && !locked_r) state_nxt = ST_HOLD;
        else if (cyc_req_i) state_nxt = ST_ADDR;
      end
      ST_ADDR: state_nxt = ST_DATA;
      // Grant only from idle, so a running cycle always ends first.
      // Block cycles end without waiting for the external ready.
      ST_DATA: begin
        if (cyc_done_i || is_refresh_indicator_r || cb_select_o)
          state_nxt = ST_IDLE;
      end
      ST_HOLD: begin
        if (!hold_s) state_nxt = ST_IDLE;
        else if (refresh_indicator) state_nxt = ST_RECL;
      end
      ST_RECL: if (!hold_s) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  always @(posedge sys_clk_i) begin
    if (in_reset) begin
      state_r <= ST_RST1;
      locked_r <= 1'b0;
      is_write_r <= 1'b0;
      is_refresh_indicator_r <= 1'b0;
      stat_r <= `LBCA_STAT_IDLE;
      cyc_ack_o <= 1'b0;
      refresh_ack_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_ack_o <= 1'b0;
      refresh_ack_o <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
        is_refresh_indicator_r <= refresh_indicator;
        stat_r <= refresh_indicator ? `LBCA_STAT_MEMRD : cyc_status_i;
        is_write_r <= ~refresh_indicator & is_wr(cyc_status_i);
        if (!refresh_indicator) locked_r <= cyc_lock_i;
      end
      if (state_r == ST_DATA && state_nxt == ST_IDLE) begin
        cyc_ack_o <= ~is_refresh_indicator_r;
        refresh_ack_o <= is_refresh_indicator_r;
      end
    end
  end
  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  wire act = (state_r == ST_ADDR) | (state_r == ST_DATA);
  wire act_nxt = (state_nxt == ST_ADDR) | (state_nxt == ST_DATA);
  // Enables follow the next state, so the pins float on the grant edge.
  wire own = ~((state_nxt == ST_HOLD) | (state_nxt == ST_RECL));
  always @(posedge sys_clk_i) begin
    if (in_reset) begin
      transceiver_enable_o <= 1'b1;
      transceiver_enable_oe_o <= (state_r != ST_RST1) | ~rst_first_r;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      strobe_oe_o <= ~rst_first_r;
      bus_status_lines_o <= `LBCA_STAT_IDLE;
      bus_status_oe_o <= ~rst_first_r;
      transceiver_direction_o <= 1'b0;
      transceiver_direction_oe_o <= 1'b0;
      bus_oe_o <= 1'b0;
      addr_latch_o <= 1'b0;
      bus_grant_out_o <= 1'b0;
      rst_first_r <= 1'b1;
    end else begin
      rst_first_r <= 1'b0;
      // Top status bit stays visible so outside logic may latch space.
      if (!act_nxt)
        bus_status_lines_o <= `LBCA_STAT_IDLE;
      else if (state_r == ST_IDLE)
        bus_status_lines_o <= refresh_indicator ? `LBCA_STAT_MEMRD : cyc_status_i;
      else
        bus_status_lines_o <= stat_r;
      transceiver_enable_o <= ~(state_r == ST_DATA);
      transceiver_direction_o <= act & is_write_r;
      rd_n_o <= ~((state_r == ST_DATA) & ~is_write_r);
      wr_n_o <= ~((state_r == ST_DATA) & is_write_r);
      addr_latch_o <= (state_r == ST_IDLE) & (state_nxt == ST_ADDR);
      transceiver_enable_oe_o <= own;
      transceiver_direction_oe_o <= own;
      strobe_oe_o <= own;
      bus_status_oe_o <= own;
      bus_oe_o <= own;
      bus_grant_out_o <= (state_nxt == ST_HOLD);
    end
  end
  // ****************************************************************
  // Control block relocation and decode
  // ****************************************************************
  wire [19:0] base = {control_block_relocation_o[11:0], 8'h00};
  wire mem_sp = control_block_relocation_o[`LBCA_RELOC_MEM_BIT];
  wire is_mem = cyc_status_i[2];
  wire io_cyc = (cyc_status_i == `LBCA_STAT_IORD) |
                (cyc_status_i == `LBCA_STAT_IOWR);
  wire mem_cyc = (cyc_status_i == `LBCA_STAT_MEMRD) |
                 (cyc_status_i == `LBCA_STAT_MEMWR);
  // In I/O space only sixteen address bits exist; base bits 19:16 must be zero.
  wire hit = mem_sp ? (mem_cyc & (cyc_addr_i[19:8] == base[19:8]))
                    : (io_cyc & is_mem == 1'b0 &
                       ({4'h0, cyc_addr_i[15:8]} == base[19:8]));
  always @(posedge sys_clk_i) begin
    if (in_reset) begin
      control_block_relocation_o <= `LBCA_RELOC_RESET;
      irq_slave_mode_o <= 1'b0;
      cb_select_o <= 1'b0;
      cb_ignore_ready_o <= 1'b0;
    end else begin
      irq_slave_mode_o <=
        control_block_relocation_o[`LBCA_RELOC_SLAVE_BIT];
      if (state_r == ST_IDLE && state_nxt == ST_ADDR && !refresh_indicator) begin
        cb_select_o <= hit;
        cb_ignore_ready_o <= hit;
        if (hit && is_wr(cyc_status_i) &&
            cyc_addr_i[7:0] == `LBCA_RELOC_OFFSET)
          control_block_relocation_o <= cyc_wdata_i;
      end else if (state_r == ST_IDLE) begin
        cb_select_o <= 1'b0;
        cb_ignore_ready_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/lbca_alt_master.sv
// Alternate bus master model that asks for the bus and yields on reclaim.
`timescale 1ns/1ps
`default_nettype none
// ****
// Alternate master
// ****
module lbca_alt_master (
  input wire logic clk_i,
  input wire logic want_i,
  input wire logic grant_i,
  output logic req_o
);
  reg had_r = 1'b0;
  reg yield_r = 1'b0;
  // Only one requester exists, so no arbitration among masters is needed.
  assign req_o = want_i && !yield_r;
  always @(posedge clk_i) begin
    had_r <= grant_i;
    // A grant taken away means the bus is wanted back, so the request goes.
    if (!want_i) begin
      yield_r <= 1'b0;
    end else if (had_r && !grant_i) begin
      yield_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: bench/lbca_monitor.sv
// Concurrent checks on the local bus controller ports.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module lbca_monitor (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire refresh_req_i,
  input wire hold_req_i,
  input wire cyc_ack_o,
  input wire addr_latch_o,
  input wire rd_n_o,
  input wire wr_n_o,
  input wire strobe_oe_o,
  input wire bus_oe_o,
  input wire bus_status_oe_o,
  input wire transceiver_enable_o,
  input wire transceiver_direction_o,
  input wire bus_grant_out_o,
  input wire reset_out_o,
  input wire cb_select_o,
  input wire cb_ignore_ready_o,
  input wire irq_slave_mode_o,
  input wire [15:0] control_block_relocation_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_float;
    bus_grant_out_o |-> !bus_oe_o && !strobe_oe_o && !bus_status_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("bus driven");
  property p_en;
    strobe_oe_o && !(rd_n_o && wr_n_o) |-> !transceiver_enable_o;
  endproperty
  a_en: assert property (p_en) else $error("enable off in cycle");
  property p_dir;
    strobe_oe_o && !(rd_n_o && wr_n_o) |-> transceiver_direction_o == rd_n_o;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_slave;
    $stable(control_block_relocation_o) [*2]
      |-> irq_slave_mode_o == control_block_relocation_o[14];
  endproperty
  a_slave: assert property (p_slave) else $error("slave mode bit");
  property p_busy;
    cyc_ack_o || addr_latch_o |-> !bus_grant_out_o;
  endproperty
  a_busy: assert property (p_busy) else $error("grant in cycle");
  property p_rcl;
    bus_grant_out_o && refresh_req_i |-> ##[1:6] !bus_grant_out_o;
  endproperty
  a_rcl: assert property (p_rcl) else $error("no reclaim");
  property p_wait;
    $fell(bus_grant_out_o) && hold_req_i |-> !bus_oe_o [*2];
  endproperty
  a_wait: assert property (p_wait) else $error("bus retaken early");
  property p_rst;
    $rose(nrst_i) |-> reset_out_o [*5];
  endproperty
  a_rst: assert property (p_rst) else $error("reset out short");
  property p_cb;
    cb_select_o && addr_latch_o |-> cb_ignore_ready_o ##[1:3] cyc_ack_o;
  endproperty
  a_cb: assert property (p_cb) else $error("ready not ignored");
endmodule
bind lbca_local_bus_ctrl lbca_monitor u_lbca_monitor (.*);
`default_nettype wire

// File: bench/lbca_local_bus_ctrl_tb_top.sv
// Self-checking bench for the local bus controller.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module lbca_local_bus_ctrl_tb_top;
  reg sys_clk_i = 0, nrst_i = 0, reset_in_n_i = 1, cyc_req_i = 0;
  reg cyc_lock_i = 0, cyc_done_i = 1, refresh_req_i = 0, want = 0;
  reg read_or_queue_strap_i = 0, upper_mem_select_i = 0;
  reg lower_mem_select_i = 0, test_pin_i = 0, en_seen, hit, exp_hit;
  reg [2:0] cyc_status_i = 0;
  reg [19:0] cyc_addr_i = 0;
  reg [15:0] cyc_wdata_i = 0, rel_m = 16'h20ff;
  reg [14:0] kinds = {3'h6, 3'h5, 3'h2, 3'h1, 3'h0};
  reg [11:0] base;
  wire hold_req_i, cyc_ack_o, refresh_ack_o, transceiver_enable_o;
  wire transceiver_enable_oe_o, transceiver_direction_o, rd_n_o, wr_n_o;
  wire transceiver_direction_oe_o, strobe_oe_o, bus_status_oe_o;
  wire addr_latch_o, bus_oe_o, bus_grant_out_o, strap_pullup_en_o;
  wire queue_status_mode_o, pin_float_emulation_mode_o, enhanced_mode_o;
  wire reset_out_o, cb_select_o, cb_ignore_ready_o, irq_slave_mode_o;
  wire [2:0] bus_status_lines_o;
  wire [15:0] control_block_relocation_o;
  integer n_errors = 0, checks_done = 0, seed = 20, tick = 0, i, k;
  lbca_local_bus_ctrl u_lbca_local_bus_ctrl (.*);
  lbca_alt_master u_lbca_alt_master (.clk_i(sys_clk_i), .want_i(want),
    .grant_i(bus_grant_out_o), .req_o(hold_req_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Ready is withheld on block hits to show that the block ignores it.
  task cyc(input [2:0] st, input [19:0] ad, input [15:0] wd, input dn);
    begin
      @(negedge sys_clk_i);
      exp_hit = st != 0 && st[2] == rel_m[12] && ad[19:8] == rel_m[11:0];
      cyc_req_i = 1;
      cyc_status_i = st;
      cyc_addr_i = ad;
      cyc_wdata_i = wd;
      cyc_done_i = dn;
      en_seen = 0;
      hit = 0;
      for (i = 0; i < 40 && cyc_ack_o !== 1'b1; i = i + 1) begin
        @(posedge sys_clk_i);
        #1;
        if (addr_latch_o === 1'b1) chk(bus_status_lines_o[2], st[2]);
        if (transceiver_enable_o === 1'b0) en_seen = 1;
        if (cb_select_o === 1'b1) hit = 1;
      end
      chk(cyc_ack_o, 1);
      chk(hit, exp_hit);
      if (exp_hit && st[1] && ad[7:0] == 8'hfe) rel_m = wd;
      @(negedge sys_clk_i);
      cyc_req_i = 0;
      cyc_done_i = 1;
      chk(en_seen, 1);
      chk(control_block_relocation_o, rel_m);
    end
  endtask
  always @(posedge sys_clk_i) begin
    tick = tick + 1;
    if (tick == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk_i);
    chk(strobe_oe_o, 0);
    chk(rd_n_o & wr_n_o & transceiver_enable_o, 1);
    chk({bus_oe_o, addr_latch_o, bus_grant_out_o}, 0);
    chk(strap_pullup_en_o, 1);
    chk(control_block_relocation_o, 16'h20ff);
    nrst_i = 1;
    test_pin_i = 1;
    repeat (6) @(negedge sys_clk_i);
    chk(queue_status_mode_o & pin_float_emulation_mode_o, 1);
    chk(strap_pullup_en_o, 0);
    chk(enhanced_mode_o, 1);
    chk(irq_slave_mode_o, 0);
    for (k = 0; k < 5; k = k + 1)
      cyc(kinds[k*3 +: 3], {4'h1, 16'(k * 4)}, $random(seed), 1);
    cyc(3'h2, 20'h0ff10, 0, 0);
    base = $random(seed);
    cyc(3'h2, 20'h0fffe, {4'h5, base}, 0);
    chk(irq_slave_mode_o, 1);
    cyc(3'h1, 20'h0ff10, 0, 1);
    cyc(3'h5, {base, 8'h10}, 0, 0);
    fork
      cyc(3'h5, 20'h12340, 0, 1);
      begin
        @(negedge sys_clk_i);
        want = 1;
        refresh_req_i = 1;
      end
    join
    for (i = 0; i < 40 && refresh_ack_o !== 1'b1; i = i + 1) begin
      @(posedge sys_clk_i);
      #1;
      chk(bus_grant_out_o, 0);
    end
    chk(refresh_ack_o, 1);
    @(negedge sys_clk_i);
    refresh_req_i = 0;
    for (i = 0; i < 40 && bus_grant_out_o !== 1'b1; i = i + 1)
      @(negedge sys_clk_i);
    chk(bus_grant_out_o, 1);
    chk({bus_oe_o, strobe_oe_o, bus_status_oe_o}, 0);
    chk(transceiver_enable_oe_o | transceiver_direction_oe_o, 0);
    refresh_req_i = 1;
    for (i = 0; i < 40 && refresh_ack_o !== 1'b1; i = i + 1) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk(refresh_ack_o, 1);
    @(negedge sys_clk_i);
    refresh_req_i = 0;
    want = 0;
    tally_and_finish;
  end
endmodule
`default_nettype wire
